// file: pwte_card_model.sv
// card and framer model facing the reader block engine
`timescale 1ns/1ns
`default_nettype none
module pwte_card_model
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    input wire logic rx_ready,
    output logic tx_ready,
    output logic tx_sof,
    output logic tx_eof,
    output logic rx_sof = 1'b0,
    output logic rx_valid = 1'b0,
    output logic [7:0] rx_data = 8'h00,
    output logic rx_last = 1'b0
);
    logic in_frame;
    // framer: start pulse on first byte, random stalls, end pulse after last
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            in_frame <= 1'b0;
            tx_ready <= 1'b0;
            tx_sof <= 1'b0;
            tx_eof <= 1'b0;
        end
        else
        begin
            tx_sof <= tx_valid && !in_frame;
            tx_eof <= tx_valid && tx_ready && tx_last;
            if (tx_valid && !in_frame)
                in_frame <= 1'b1;
            else if (tx_valid && tx_ready && tx_last)
                in_frame <= 1'b0;
            tx_ready <= in_frame && tx_valid && !tx_ready
                && ($urandom % 3 != 0);
        end
    end
    // card frame: each byte held until taken, idle gap between bytes
    task automatic send(input logic [7:0] f[$], input int gap,
        output logic timed_out);
        int n;
        timed_out = 1'b0;
        @(posedge clk) #1 rx_sof = 1'b1;
        @(posedge clk) #1 rx_sof = 1'b0;
        foreach (f[i])
        begin
            if (i > 0 && gap > 0)
            begin
                rx_valid = 1'b0;
                rx_data = ~rx_data;
                repeat (gap) @(posedge clk) #1;
            end
            rx_valid = 1'b1;
            rx_data = f[i];
            rx_last = 1'(i == f.size() - 1);
            for (n = 0; n < 500 && !rx_ready; n++) @(posedge clk) #1;
            timed_out = timed_out || !rx_ready;
            @(posedge clk) #1;
        end
        rx_valid = 1'b0;
        rx_last = 1'b0;
        rx_data = ~rx_data;
    endtask
endmodule
`default_nettype wire

// file: pwte_core.sv
// reader block engine: I-block send, WTX answer, frame waiting timer, NAK
`timescale 1ns/1ns
`default_nettype none
module pwte_core
    import pwte_pkg::*;
#(
    parameter int GAP_LIMIT = GAP_LIMIT_CYC
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [3:0] fwi,
    input wire logic cid_en,
    input wire logic [3:0] cid,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_data,
    input wire logic cmd_last,
    output logic cmd_ready,
    output logic tx_valid,
    output logic [7:0] tx_data,
    output logic tx_last,
    input wire logic tx_ready,
    input wire logic tx_sof,
    input wire logic tx_eof,
    input wire logic rx_sof,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_last,
    input wire logic rx_err,
    output logic rx_ready,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic rsp_last,
    output logic rsp_err,
    input wire logic rsp_ready,
    output logic block_num,
    output logic wtx_active,
    output logic [WTXM_W-1:0] wtxm,
    output logic fwt_expired,
    output logic [FRT_W-1:0] frt_cycles,
    output logic busy
);
    localparam logic [GAP_W-1:0] GAP_END = GAP_W'(GAP_LIMIT - 1);

    pwte_state_t state_ff, nxt_state;
    pwte_kind_t kind_ff, nxt_kind;
    logic [1:0] txi_ff, nxt_txi, rxi_ff, nxt_rxi;
    logic tx_valid_ff, nxt_tx_valid, tx_last_ff, nxt_tx_last;
    logic [7:0] tx_data_ff, nxt_tx_data, pcb_ff, nxt_pcb;
    logic cmd_ready_ff, nxt_cmd_ready;
    logic bn_ff, nxt_bn, wtx_ff, nxt_wtx, exp_ff, nxt_exp;
    logic busy_ff, nxt_busy;
    logic [WTXM_W-1:0] wtxm_ff, nxt_wtxm;
    logic [16:0] acc_ff, nxt_acc;
    logic [17:0] acc_sum;
    logic [31:0] cnt_ff, nxt_cnt, lim_ff, nxt_lim, fwt_norm, fwt_temp;
    logic [GAP_W-1:0] gap_ff, nxt_gap;
    logic frt_run_ff, nxt_frt_run;
    logic [FRT_W-1:0] frt_cnt_ff, nxt_frt_cnt, frt_ff, nxt_frt;
    logic [3:0] fwi_eff;
    logic fc_tick, slot, rx_take, fifo_ready, push;
    logic [7:0] pcb_cur, tx_pcb, hdr_byte;
    logic has_cid, data_pos, is_i, is_wtx, hdr_end, hdr_last;
    logic [RSP_W-1:0] rsp_word;

    assign cmd_ready = cmd_ready_ff;
    assign tx_valid = tx_valid_ff;
    assign tx_data = tx_data_ff;
    assign tx_last = tx_last_ff;
    assign rx_ready = fifo_ready;
    assign block_num = bn_ff;
    assign wtx_active = wtx_ff;
    assign wtxm = wtxm_ff;
    assign fwt_expired = exp_ff;
    assign frt_cycles = frt_ff;
    assign busy = busy_ff;
    assign rsp_data = rsp_word[7:0];
    assign rsp_last = rsp_word[RSP_LAST_BIT];
    assign rsp_err = rsp_word[RSP_ERR_BIT];

    pwte_fifo #(
        .W(RSP_W),
        .DEPTH(RSP_DEPTH)
    ) u_rsp_fifo (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .in_valid(push),
        .in_data({rx_err && rx_last, rx_last, rx_data}),
        .in_ready(fifo_ready),
        .out_valid(rsp_valid),
        .out_data(rsp_word),
        .out_ready(rsp_ready)
    );

    always_comb
    begin
        // waiting times in carrier periods, 32 bits hold 59 x 2^26
        fwi_eff = (fwi > FWI_MAX) ? FWI_MAX : fwi;
        fwt_norm = FWT_UNIT_FC << fwi_eff;
        fwt_temp = fwt_norm * 32'(wtxm_ff);
        // spare top bit: the sum passes the 17-bit range before the wrap
        acc_sum = {1'b0, acc_ff} + {1'b0, ACC_STEP};
        fc_tick = acc_sum >= {1'b0, ACC_MOD};
        nxt_acc = fc_tick ? 17'(acc_sum - {1'b0, ACC_MOD})
            : acc_sum[16:0];
        slot = !tx_valid_ff || tx_ready;
        rx_take = rx_valid && fifo_ready;
        pcb_cur = (rxi_ff == 2'd0) ? rx_data : pcb_ff;
        has_cid = pcb_cur[PCB_CID_POS];
        data_pos = rxi_ff > {1'b0, has_cid};
        is_i = (pcb_cur & PCB_I_MSK) == PCB_I;
        is_wtx = (pcb_cur & PCB_WTX_MSK) == PCB_WTX;
        push = (state_ff == S_RX) && rx_valid && is_i && data_pos;
        // outgoing control byte per frame kind
        case (kind_ff)
            K_I: tx_pcb = PCB_I | (bn_ff ? PCB_BN_BIT : 8'h00);
            K_WTX: tx_pcb = PCB_WTX;
            K_NAK: tx_pcb = PCB_NAK | (bn_ff ? PCB_BN_BIT : 8'h00);
            default: tx_pcb = PCB_NAK;
        endcase
        if (cid_en)
            tx_pcb = tx_pcb | PCB_CID_BIT;
        hdr_end = (txi_ff == 2'd0 && !cid_en) || (txi_ff == 2'd1 && cid_en);
        if (txi_ff == 2'd0)
            hdr_byte = tx_pcb;
        else if (txi_ff == 2'd1 && cid_en)
            hdr_byte = {4'h0, cid};
        else
            hdr_byte = {2'b00, wtxm_ff};
        case (kind_ff)
            K_NAK: hdr_last = hdr_end;
            K_WTX: hdr_last = txi_ff != 2'd0 && !(txi_ff == 2'd1 && cid_en);
            default: hdr_last = 1'b0;
        endcase

        nxt_state = state_ff;
        nxt_kind = kind_ff;
        nxt_txi = txi_ff;
        nxt_rxi = rxi_ff;
        nxt_tx_valid = tx_valid_ff && !tx_ready;
        nxt_tx_data = tx_data_ff;
        nxt_tx_last = tx_last_ff;
        nxt_pcb = pcb_ff;
        nxt_bn = bn_ff;
        nxt_wtx = wtx_ff;
        nxt_wtxm = wtxm_ff;
        nxt_exp = 1'b0;
        nxt_cnt = cnt_ff;
        nxt_lim = lim_ff;
        nxt_gap = gap_ff;

        case (state_ff)
            S_IDLE:
            begin
                if (cmd_valid)
                begin
                    nxt_kind = K_I;
                    nxt_txi = 2'd0;
                    nxt_state = S_TXHDR;
                end
            end
            S_TXHDR:
            begin
                if (slot)
                begin
                    nxt_tx_valid = 1'b1;
                    nxt_tx_data = hdr_byte;
                    nxt_tx_last = hdr_last;
                    nxt_txi = txi_ff + 2'd1;
                    if (hdr_last)
                        nxt_state = S_TXEND;
                    else if (kind_ff == K_I && hdr_end)
                        nxt_state = S_TXCMD;
                end
            end
            S_TXCMD:
            begin
                if (cmd_ready_ff && cmd_valid)
                begin
                    nxt_tx_valid = 1'b1;
                    nxt_tx_data = cmd_data;
                    nxt_tx_last = cmd_last;
                    if (cmd_last)
                        nxt_state = S_TXEND;
                end
            end
            S_TXEND:
            begin
                // timer starts at the end of our own frame
                if (tx_eof)
                begin
                    nxt_cnt = '0;
                    // restart tick phase so the wait never ends a tick early
                    nxt_acc = '0;
                    nxt_wtx = kind_ff == K_WTX;
                    nxt_lim = (kind_ff == K_WTX) ? fwt_temp : fwt_norm;
                    nxt_state = S_WAIT;
                end
            end
            S_WAIT:
            begin
                if (fc_tick)
                    nxt_cnt = cnt_ff + 32'd1;
                if (rx_sof)
                begin
                    nxt_wtx = 1'b0;
                    nxt_rxi = 2'd0;
                    nxt_gap = '0;
                    nxt_state = S_RX;
                end
                else if (cnt_ff >= lim_ff)
                begin
                    nxt_exp = 1'b1;
                    nxt_kind = K_NAK;
                    nxt_txi = 2'd0;
                    nxt_state = S_TXHDR;
                end
            end
            S_RX:
            begin
                nxt_gap = gap_ff + 1'b1;
                if (rx_take)
                begin
                    nxt_gap = '0;
                    if (rxi_ff != 2'd2)
                        nxt_rxi = rxi_ff + 2'd1;
                    if (rxi_ff == 2'd0)
                        nxt_pcb = rx_data;
                    if (is_wtx && data_pos)
                        nxt_wtxm = rx_data[WTXM_W-1:0];
                    if (rx_last)
                    begin
                        nxt_txi = 2'd0;
                        nxt_state = S_TXHDR;
                        nxt_kind = K_NAK;
                        if (rx_err)
                            nxt_kind = K_NAK;
                        else if (is_i && pcb_cur[PCB_BN_POS] == bn_ff)
                        begin
                            nxt_bn = !bn_ff;
                            nxt_state = S_IDLE;
                        end
                        else if (is_wtx && data_pos &&
                                 rx_data[WTXM_W-1:0] != '0)
                            nxt_kind = K_WTX;
                    end
                end
                else if (gap_ff >= GAP_END)
                begin
                    // silence past char time plus max guard time
                    nxt_kind = K_NAK;
                    nxt_txi = 2'd0;
                    nxt_state = S_TXHDR;
                end
            end
            default:
                nxt_state = S_IDLE;
        endcase
        nxt_cmd_ready = (nxt_state == S_TXCMD) && !nxt_tx_valid;
        nxt_busy = nxt_state != S_IDLE;
    end

    // response time from end of received frame to start of next sent frame
    always_comb
    begin
        nxt_frt_run = frt_run_ff;
        nxt_frt_cnt = frt_cnt_ff;
        nxt_frt = frt_ff;
        if (frt_run_ff && frt_cnt_ff != '1)
            nxt_frt_cnt = frt_cnt_ff + 1'b1;
        if (frt_run_ff && tx_sof)
        begin
            nxt_frt = frt_cnt_ff;
            nxt_frt_run = 1'b0;
        end
        if (state_ff == S_RX && rx_take && rx_last)
        begin
            nxt_frt_run = 1'b1;
            nxt_frt_cnt = '0;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_ff <= S_IDLE;
            kind_ff <= K_I;
            txi_ff <= '0;
            rxi_ff <= '0;
            tx_valid_ff <= 1'b0;
            tx_data_ff <= '0;
            tx_last_ff <= 1'b0;
            pcb_ff <= '0;
            cmd_ready_ff <= 1'b0;
            bn_ff <= 1'b0;
            wtx_ff <= 1'b0;
            wtxm_ff <= '0;
            exp_ff <= 1'b0;
            busy_ff <= 1'b0;
            acc_ff <= '0;
            cnt_ff <= '0;
            lim_ff <= '0;
            gap_ff <= '0;
            frt_run_ff <= 1'b0;
            frt_cnt_ff <= '0;
            frt_ff <= '0;
        end
        else if (ce)
        begin
            state_ff <= nxt_state;
            kind_ff <= nxt_kind;
            txi_ff <= nxt_txi;
            rxi_ff <= nxt_rxi;
            tx_valid_ff <= nxt_tx_valid;
            tx_data_ff <= nxt_tx_data;
            tx_last_ff <= nxt_tx_last;
            pcb_ff <= nxt_pcb;
            cmd_ready_ff <= nxt_cmd_ready;
            bn_ff <= nxt_bn;
            wtx_ff <= nxt_wtx;
            wtxm_ff <= nxt_wtxm;
            exp_ff <= nxt_exp;
            busy_ff <= nxt_busy;
            acc_ff <= nxt_acc;
            cnt_ff <= nxt_cnt;
            lim_ff <= nxt_lim;
            gap_ff <= nxt_gap;
            frt_run_ff <= nxt_frt_run;
            frt_cnt_ff <= nxt_frt_cnt;
            frt_ff <= nxt_frt;
        end
    end
endmodule
`default_nettype wire

// file: pwte_core_sva.sv
// assertion checker for the reader wait-time-extension engine
`timescale 1ns/1ns
`default_nettype none
module pwte_core_sva
    import pwte_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic cid_en,
    input wire logic cmd_valid,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    input wire logic tx_ready,
    input wire logic tx_eof,
    input wire logic rx_sof,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_data,
    input wire logic rsp_ready,
    input wire logic block_num,
    input wire logic wtx_active,
    input wire logic [WTXM_W-1:0] wtxm,
    input wire logic fwt_expired,
    input wire logic busy
);
    logic wtx_hdr_ff, first_ff;
    logic nxt_wtx_hdr, nxt_first;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // marks the multiplier byte that follows a WTX response header sent without CID
    always_comb
    begin
        nxt_wtx_hdr = wtx_hdr_ff;
        nxt_first = first_ff;
        if (tx_valid && tx_ready)
        begin
            // only the leading byte of a frame is a control byte
            nxt_wtx_hdr = first_ff && !tx_last && tx_data == PCB_WTX;
            nxt_first = tx_last;
        end
    end
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wtx_hdr_ff <= 1'b0;
            first_ff <= 1'b1;
        end
        else
        begin
            wtx_hdr_ff <= nxt_wtx_hdr;
            first_ff <= nxt_first;
        end
    end
    property p_ihdr;
        !busy && cmd_valid |-> ##2 tx_valid && tx_data == (PCB_I
            | (cid_en ? PCB_CID_BIT : 8'h00) | {7'h00, block_num});
    endproperty
    a_ihdr: assert property (p_ihdr)
        else $error("bad block header");
    property p_bn_hold;
        tx_valid |-> $stable(block_num);
    endproperty
    a_bn_hold: assert property (p_bn_hold)
        else $error("block number moved during send");
    property p_echo;
        tx_valid && wtx_hdr_ff |-> tx_last && tx_data[5:0] == wtxm;
    endproperty
    a_echo: assert property (p_echo)
        else $error("multiplier not echoed");
    property p_wtx_rise;
        $rose(wtx_active) |-> $past(tx_eof);
    endproperty
    a_wtx_rise: assert property (p_wtx_rise)
        else $error("extension started off frame end");
    property p_wtx_end;
        wtx_active && rx_sof |=> !wtx_active;
    endproperty
    a_wtx_end: assert property (p_wtx_end)
        else $error("extension kept past card frame");
    property p_nak;
        fwt_expired |=> tx_valid && tx_last == !cid_en && tx_data == (PCB_NAK
            | (cid_en ? PCB_CID_BIT : 8'h00) | {7'h00, block_num});
    endproperty
    a_nak: assert property (p_nak)
        else $error("no negative acknowledge after timeout");
    property p_exp_pulse;
        fwt_expired |=> !fwt_expired;
    endproperty
    a_exp_pulse: assert property (p_exp_pulse)
        else $error("timeout flag not a pulse");
    property p_exp_quiet;
        fwt_expired |-> busy && !tx_valid;
    endproperty
    a_exp_quiet: assert property (p_exp_quiet)
        else $error("timeout while sending");
    property p_rsp_hold;
        rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data);
    endproperty
    a_rsp_hold: assert property (p_rsp_hold)
        else $error("response byte dropped");
    c_expired: cover property (fwt_expired);
    c_wtx_end: cover property (wtx_active && rx_sof);
    c_rsp_stall: cover property (rsp_valid && !rsp_ready);
endmodule
bind pwte_core pwte_core_sva u_pwte_core_sva (.clk, .nrst, .cid_en,
    .cmd_valid, .tx_valid, .tx_data, .tx_last, .tx_ready, .tx_eof, .rx_sof,
    .rsp_valid, .rsp_data, .rsp_ready, .block_num, .wtx_active, .wtxm,
    .fwt_expired, .busy);
`default_nettype wire

// file: pwte_fifo.sv
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module pwte_fifo #(
    parameter int W = 10,
    parameter int DEPTH = 16
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);
    localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

    logic [W-1:0] mem_ff [DEPTH];
    logic [W-1:0] nxt_mem [DEPTH];
    logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
    logic [CW-1:0] cnt_ff, nxt_cnt;
    logic in_ready_ff, nxt_in_ready, out_valid_ff, nxt_out_valid;
    logic push, pop;

    assign in_ready = in_ready_ff;
    assign out_valid = out_valid_ff;
    assign out_data = mem_ff[rd_ff];

    always_comb
    begin
        push = in_valid && in_ready_ff;
        pop = out_valid_ff && out_ready;
        nxt_mem = mem_ff;
        nxt_wr = wr_ff;
        nxt_rd = rd_ff;
        nxt_cnt = cnt_ff;
        if (push)
        begin
            nxt_mem[wr_ff] = in_data;
            nxt_wr = (wr_ff == LAST_IDX) ? '0 : wr_ff + 1'b1;
        end
        if (pop)
            nxt_rd = (rd_ff == LAST_IDX) ? '0 : rd_ff + 1'b1;
        if (push && !pop)
            nxt_cnt = cnt_ff + 1'b1;
        else if (pop && !push)
            nxt_cnt = cnt_ff - 1'b1;
        nxt_in_ready = nxt_cnt != FULL;
        nxt_out_valid = nxt_cnt != '0;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < DEPTH; i++)
                mem_ff[i] <= '0;
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
            in_ready_ff <= 1'b0;
            out_valid_ff <= 1'b0;
        end
        else if (ce)
        begin
            mem_ff <= nxt_mem;
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
            cnt_ff <= nxt_cnt;
            in_ready_ff <= nxt_in_ready;
            out_valid_ff <= nxt_out_valid;
        end
    end
endmodule
`default_nettype wire

// file: pwte_pkg.sv
// constants, types and timing for the reader wait-time-extension engine
// Functional notes
// - reader answers S(WTX) echoing the multiplier in INF bits b6..b1.
// - after the WTX response wait WTXM x 256 x 16 fc x 2^FWI.
// - character gaps up to the 19 us extra guard time are not errors.
// - response time runs from end of received frame to start of sent frame.
// - a card I-block answer inside the waiting time goes up to the host.
// - after a completed exchange the next I-block uses the toggled block number.
// - sending a new I-block restarts the timer with the normal FWT.
// - on a mute card R(NAK) is sent only once the FWT has fully run out.
// - FWI values up to 14 give correct normal and extended times.
// - multipliers up to 59 are echoed and scaled correctly.
// - NAK for block 0 is B2, or BA plus CID byte, then CRC.
package pwte_pkg;
    // clock and carrier rates in kHz drive the fc tick accumulator
    localparam int CLK_KHZ = 125000;
    localparam int FC_KHZ = 13560;
    localparam logic [16:0] ACC_MOD = 17'(CLK_KHZ);
    localparam logic [16:0] ACC_STEP = 17'(FC_KHZ);
    // character time plus largest extra guard time, in ns
    localparam int EGT_MAX_NS = 19000;
    localparam int CHAR_NS = 94400;
    localparam int CLK_PER_US = CLK_KHZ / 1000;
    localparam int GAP_LIMIT_CYC = ((CHAR_NS + EGT_MAX_NS) * CLK_PER_US + 999)
        / 1000;
    localparam int GAP_W = 16;
    // waiting time unit 256 x 16 carrier periods
    localparam logic [31:0] FWT_UNIT_FC = 32'(256 * 16);
    localparam logic [3:0] FWI_MAX = 4'he;
    localparam int WTXM_W = 6;
    localparam int FRT_W = 24;
    // block control bytes
    localparam logic [7:0] PCB_I = 8'h02;
    localparam logic [7:0] PCB_I_MSK = 8'he2;
    localparam logic [7:0] PCB_WTX = 8'hf2;
    localparam logic [7:0] PCB_WTX_MSK = 8'hf7;
    localparam logic [7:0] PCB_NAK = 8'hb2;
    localparam logic [7:0] PCB_CID_BIT = 8'h08;
    localparam logic [7:0] PCB_BN_BIT = 8'h01;
    localparam int PCB_CID_POS = 3;
    localparam int PCB_BN_POS = 0;
    // response buffer word: {err, last, data}
    localparam int RSP_W = 10;
    localparam int RSP_DEPTH = 16;
    localparam int RSP_ERR_BIT = 9;
    localparam int RSP_LAST_BIT = 8;
    typedef enum logic [2:0] {
        S_IDLE, S_TXHDR, S_TXCMD, S_TXEND, S_WAIT, S_RX
    } pwte_state_t;
    typedef enum logic [1:0] {K_I, K_WTX, K_NAK} pwte_kind_t;
endpackage

// file: tb_pcd_wait_time_extension.sv
// bench: multiplier echo, extended wait, buffer fill, mute card timeout
`timescale 1ns/1ns
`default_nettype none
module tb_pcd_wait_time_extension;
    import pwte_pkg::*;
    localparam int FWT0 = 4096 * CLK_KHZ / FC_KHZ;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] fwi = 4'h0;
    logic cmd_valid = 1'b0;
    logic [7:0] cmd_data = 8'h00;
    logic cmd_last = 1'b0;
    logic rsp_ready = 1'b0;
    logic hold_rsp = 1'b0;
    logic saw_full = 1'b0;
    logic bn = 1'b0;
    logic cid_en = 1'b0;
    logic [3:0] cid = 4'h0;
    logic [WTXM_W-1:0] wtxm;
    logic [FRT_W-1:0] frt_cycles;
    logic cmd_ready, tx_valid, tx_last, tx_ready, tx_sof, tx_eof, rx_sof;
    logic rx_valid, rx_last, rx_ready, rsp_valid, rsp_last, rsp_err;
    logic block_num, wtx_active, fwt_expired, busy;
    logic [7:0] tx_data, rx_data, rsp_data;
    logic [9:0] tx_q[$], rsp_q[$];
    int fail_count = 0, comparisons = 0, cyc = 0, eof_cnt = 0;
    int t_eof = 0, t_sof = 0, t_rx = 0;
    int fw[3] = '{14, 1, 0};
    int wm[3] = '{1, 3, 59};
    pwte_core #(.GAP_LIMIT(200)) u_pwte_core (.clk, .nrst, .ce(1'b1), .fwi,
        .cid_en, .cid, .cmd_valid, .cmd_data, .cmd_last,
        .cmd_ready, .tx_valid, .tx_data, .tx_last, .tx_ready, .tx_sof,
        .tx_eof, .rx_sof, .rx_valid, .rx_data, .rx_last, .rx_err(1'b0),
        .rx_ready, .rsp_valid, .rsp_data, .rsp_last, .rsp_err, .rsp_ready,
        .block_num, .wtx_active, .wtxm, .fwt_expired, .frt_cycles,
        .busy);
    pwte_card_model u_pwte_card_model (.clk, .nrst, .tx_valid, .tx_data,
        .tx_last, .rx_ready, .tx_ready, .tx_sof, .tx_eof, .rx_sof, .rx_valid,
        .rx_data, .rx_last);
    always #4 clk = ~clk;
    always @(posedge clk)
    begin
        #1 rsp_ready = !hold_rsp && ($urandom % 4 != 0);
    end
    task automatic conclude;
        if (fail_count == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic bail(input logic hit);
        if (hit)
        begin
            fail_count++;
            conclude();
        end
    endtask
    task automatic chk_word(input string nm, input logic [23:0] exp,
        input logic [23:0] got);
        comparisons++;
        if (exp !== got)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic chk_byte(input string nm, ref logic [9:0] q[$],
        input logic [9:0] got);
        logic [9:0] exp;
        exp = (q.size() > 0) ? q.pop_front() : 10'h3ff;
        comparisons++;
        if (exp !== got)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic chk_flag(input string nm, input logic exp, input logic got);
        comparisons++;
        if (exp !== got)
        begin
            fail_count++;
            $display("ERROR %s expected %b seen %b", nm, exp, got);
        end
    endtask
    task automatic wait_eof(input int lim);
        int n, e;
        e = eof_cnt;
        for (n = 0; n < lim && eof_cnt == e; n++) @(posedge clk) #1;
        bail(eof_cnt == e);
    endtask
    task automatic send_cmd(input logic [7:0] f[$]);
        int n;
        tx_q.push_back({2'b00, PCB_I | (cid_en ? PCB_CID_BIT : 8'h00)
            | {7'h00, bn}});
        if (cid_en)
            tx_q.push_back({2'b00, 4'h0, cid});
        foreach (f[i])
        begin
            tx_q.push_back({1'b0, 1'(i == f.size() - 1), f[i]});
            cmd_valid = 1'b1;
            cmd_data = f[i];
            cmd_last = 1'(i == f.size() - 1);
            for (n = 0; n < 200 && !cmd_ready; n++) @(posedge clk) #1;
            bail(!cmd_ready);
            @(posedge clk) #1;
        end
        cmd_valid = 1'b0;
        cmd_last = 1'b0;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (tx_eof)
        begin
            eof_cnt++;
            t_eof = cyc;
        end
        if (tx_sof)
            t_sof = cyc;
        if (rx_valid && rx_ready && rx_last)
            t_rx = cyc;
        if (nrst && rx_valid && !rx_ready)
            saw_full = 1'b1;
        if (tx_valid && tx_ready)
            chk_byte("tx", tx_q, {1'b0, tx_last, tx_data});
        if (rsp_valid && rsp_ready)
            chk_byte("rsp", rsp_q, {rsp_err, rsp_last, rsp_data});
    end
    initial
    begin
        logic [7:0] f[$];
        int n, d;
        logic to;
        void'($urandom(32'ha5732813));
        repeat (6) @(posedge clk);
        #1 nrst = 1'b1;
        @(posedge clk) #1;
        foreach (fw[a])
        begin
            foreach (wm[b])
            begin
                fwi = 4'(fw[a]);
                send_cmd('{8'($urandom), 8'($urandom)});
                wait_eof(500);
                tx_q.push_back({2'b00, PCB_WTX});
                tx_q.push_back({2'b01, 8'(wm[b])});
                u_pwte_card_model.send('{PCB_WTX, 8'(wm[b])}, 0, to);
                bail(to);
                wait_eof(500);
                chk_word("wtxm", 24'(wm[b]), 24'(wtxm));
                chk_word("frt", 24'(t_sof - t_rx - 1), frt_cycles);
                n = (a == 2 && b == 2) ? 20 : 3;
                f = '{PCB_I | {7'h00, bn}};
                for (int i = 0; i < n; i++)
                begin
                    f.push_back(8'($urandom));
                    rsp_q.push_back({1'b0, 1'(i == n - 1), f[i + 1]});
                end
                hold_rsp = 1'(n > 3);
                fork
                    u_pwte_card_model.send(f, (a == 1) ? 150 : 0,
                        to);
                    begin
                        repeat (80) @(posedge clk);
                        hold_rsp = 1'b0;
                    end
                join
                bail(to);
                repeat (40) @(posedge clk) #1;
                bn = ~bn;
            end
        end
        chk_flag("fifo_full", 1'b1, saw_full);
        chk_flag("rsp_drained", 1'b1, 1'(rsp_q.size() == 0));
        fwi = 4'h0;
        cid_en = 1'b1;
        cid = 4'($urandom);
        send_cmd('{8'($urandom)});
        wait_eof(500);
        d = t_eof;
        tx_q.push_back({2'b00, PCB_NAK | PCB_CID_BIT | {7'h00, bn}});
        tx_q.push_back({2'b01, 4'h0, cid});
        wait_eof(40000);
        d = t_sof - d;
        chk_flag("nak_delay", 1'b1, 1'(d >= FWT0 && d <= FWT0 + 12));
        conclude();
    end
endmodule
`default_nettype wire
